// ### cbse_pkg.sv
// shared constants and types for the bit, stack and i/o execute block
package cbse_pkg;

	localparam int REG_COUNT = 32;
	localparam int IO_COUNT  = 64;

	// i/o locations that the core itself uses
	localparam logic [5:0] IO_PTR_EXT = 6'h3b;
	localparam logic [5:0] IO_SP_LO   = 6'h3d;
	localparam logic [5:0] IO_SP_HI   = 6'h3e;
	localparam logic [5:0] IO_STATUS  = 6'h3f;

	// register bus map
	localparam logic [6:0] BUS_IO_BASE = 7'h20;
	localparam logic [6:0] BUS_IO_TOP  = 7'h5f;

	// status_flags_register bit positions
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;

	// timing in cycles
	localparam int CYC_PUSH       = 1;
	localparam int CYC_POP        = 2;
	localparam int CYC_SRAM_EXTRA = 1;
	localparam logic [1:0] PUSH_LOAD = 2'(CYC_PUSH + CYC_SRAM_EXTRA - 2);
	localparam logic [1:0] POP_LOAD  = 2'(CYC_POP + CYC_SRAM_EXTRA - 2);

	localparam logic [15:0] PM_STEP      = 16'h0002;
	localparam logic [15:0] SP_RESET     = 16'h3fff;
	localparam logic [15:0] INT_SRAM_TOP = 16'h3fff;

	typedef enum logic [4:0] {
		op_no_operation,
		op_break,
		op_sleep,
		op_watchdog_restart,
		op_io_read,
		op_io_write,
		op_stack_push,
		op_stack_pop,
		op_program_memory_store,
		op_logical_left_shift,
		op_logical_right_shift,
		op_rotate_left_carry,
		op_rotate_right_carry,
		op_arithmetic_right_shift,
		op_io_bit_force_one,
		op_io_bit_force_zero,
		op_bit_to_transfer_flag,
		op_transfer_flag_to_bit,
		op_indexed_flag_force_one,
		op_indexed_flag_force_zero
	} cbse_op_t;

	typedef enum logic [1:0] {
		fill_zero,
		fill_carry,
		fill_keep
	} cbse_fill_t;

endpackage

// ### cbse_bit_write.sv
// writes one selected bit of a word, leaving the others as they were
`timescale 1ns/100ps
`default_nettype none
module cbse_bit_write #(
	parameter int W  = 8,
	parameter int IW = $clog2(W)
) (
	input  wire logic [W-1:0]  din,
	input  wire logic [IW-1:0] idx,
	input  wire logic          val,
	output logic      [W-1:0]  dout
);

	always_comb begin
		dout      = din;
		dout[idx] = val;
	end

endmodule // cbse_bit_write
`default_nettype wire

// ### cbse_shift_unit.sv
// one-bit shifter with its status flag results
`timescale 1ns/100ps
`default_nettype none
module cbse_shift_unit (
	input  wire logic [7:0]         din,
	input  wire logic               cin,
	input  wire logic               left,
	input  wire cbse_pkg::cbse_fill_t fill,
	input  wire logic [7:0]         sts_in,
	output logic      [7:0]         res,
	output logic      [7:0]         sts_out
);

	logic fill_bit;

	always_comb begin
		fill_bit = 1'b0;
		sts_out  = sts_in;
		if (fill == cbse_pkg::fill_carry) begin
			fill_bit = cin;
		end else if (fill == cbse_pkg::fill_keep) begin
			fill_bit = din[7];
		end
		if (left) begin
			res                        = {din[6:0], fill_bit}; // [RULE_05]
			sts_out[cbse_pkg::FLAG_C]  = din[7];
			sts_out[cbse_pkg::FLAG_H]  = din[3];
		end else begin
			// h stays as it was for right shifts
			res                        = {fill_bit, din[7:1]}; // [RULE_06]
			sts_out[cbse_pkg::FLAG_C]  = din[0];
		end
		sts_out[cbse_pkg::FLAG_Z] = (res == 8'h00);
		sts_out[cbse_pkg::FLAG_N] = res[7];
		sts_out[cbse_pkg::FLAG_V] = res[7] ^ sts_out[cbse_pkg::FLAG_C];
	end

endmodule // cbse_shift_unit
`default_nettype wire

// ### cbse_exec_core.sv
// execute stage for i/o, stack, shift, bit and flag operations
// Functional notes
// [RULE_01] program_memory_store writes r1:r0 at the extended z address, then adds 2 to z, no flags touched.
// [RULE_02] io read copies an i/o location to a register and io write the reverse, 1 cycle, flags kept.
// [RULE_03] push stores a register on the stack in 1 cycle plus memory extra, flags kept.
// [RULE_04] pop loads a register from the stack in 2 cycles plus memory extra, flags kept.
// [RULE_05] left shifts move bit n to n+1, bit 7 to carry, fill 0 or old carry, update z c n v h.
// [RULE_06] right shifts move bit n+1 to n, bit 0 to carry, fill 0, old carry or keep bit 7, h kept.
// [RULE_07] io_bit_force_one/zero change one bit of a low i/o register in 1 cycle, no flags.
// [RULE_08] bit_to_transfer_flag copies register bit b into t in 1 cycle, only t changes.
// [RULE_09] transfer_flag_to_bit copies t into register bit b in 1 cycle, flags kept.
// [RULE_10] each flag can be forced to one or zero by index, only that flag changes, 1 cycle.
// [RULE_11] break, no_operation, sleep and watchdog_restart take 1 cycle and keep every flag.
// [RULE_12] stack counts hold for internal memory only; external accesses wait for the memory.
// [RULE_13] an internal sram access costs one cycle more than the base count.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module cbse_exec_core #(
	parameter logic [15:0] SP_INIT  = cbse_pkg::SP_RESET,
	parameter logic [15:0] SRAM_TOP = cbse_pkg::INT_SRAM_TOP
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              op_valid,
	input  wire cbse_pkg::cbse_op_t op_code,
	input  wire logic [4:0]        op_reg,
	input  wire logic [5:0]        op_io,
	input  wire logic [2:0]        op_bit,
	output logic                   op_ready,
	output logic                   op_done_q,
	input  wire logic [6:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_we,
	input  wire logic              reg_re,
	output logic      [7:0]        reg_rdata_q,
	output logic                   dm_req_q,
	output logic                   dm_we_q,
	output logic      [15:0]       dm_addr_q,
	output logic      [7:0]        dm_wdata_q,
	input  wire logic [7:0]        dm_rdata,
	input  wire logic              dm_ack,
	output logic                   pm_req_q,
	output logic      [23:0]       pm_addr_q,
	output logic      [15:0]       pm_wdata_q,
	input  wire logic              pm_ack,
	output logic                   sleep_req_q,
	output logic                   break_req_q,
	output logic                   wdt_restart_q
);

	typedef enum {st_idle, st_mem, st_pmem} cbse_state_t;

	cbse_state_t state_q;
	logic [7:0]  rf_q [cbse_pkg::REG_COUNT];
	logic [7:0]  io_q [cbse_pkg::IO_COUNT];
	logic [1:0]  cnt_q;
	logic        pop_q;
	logic        ext_q;
	logic [4:0]  dst_q;
	logic        take;
	logic        mem_done;
	logic        pm_done;
	logic        multi;
	logic [7:0]  status;
	logic [15:0] sp;
	logic [15:0] sp_up;
	logic [15:0] zptr;
	logic [5:0]  bus_io;
	logic [5:0]  bit_io;
	logic [7:0]  sh_res;
	logic [7:0]  sh_sts;
	logic        sh_left;
	logic        val_io;
	logic        val_flag;
	logic [7:0]  iobit_res;
	logic [7:0]  tbit_res;
	logic [7:0]  flag_res;
	logic [7:0]  tflag_res;
	cbse_pkg::cbse_fill_t sh_fill;

	assign op_ready = (state_q == st_idle);
	assign take     = op_valid && op_ready;
	assign status   = io_q[cbse_pkg::IO_STATUS];
	assign sp       = {io_q[cbse_pkg::IO_SP_HI], io_q[cbse_pkg::IO_SP_LO]};
	assign sp_up    = sp + 16'h0001;
	assign zptr     = {rf_q[31], rf_q[30]};
	assign bus_io   = 6'(reg_addr - cbse_pkg::BUS_IO_BASE);
	// bit forcing only reaches the lower half of the i/o space
	assign bit_io   = {1'b0, op_io[4:0]};
	assign multi    = (op_code == cbse_pkg::op_stack_push) || (op_code == cbse_pkg::op_stack_pop)
		|| (op_code == cbse_pkg::op_program_memory_store);
	// internal memory runs on a fixed count, external waits for its ack
	assign mem_done = (state_q == st_mem) && (ext_q ? dm_ack : (cnt_q == 2'h0)); // [RULE_12]
	assign pm_done  = (state_q == st_pmem) && pm_ack;
	assign sh_left  = (op_code == cbse_pkg::op_logical_left_shift) || (op_code == cbse_pkg::op_rotate_left_carry);
	assign val_io   = (op_code == cbse_pkg::op_io_bit_force_one);
	assign val_flag = (op_code == cbse_pkg::op_indexed_flag_force_one);

	// rotates feed the old carry in, the arithmetic form copies bit 7 to keep the sign
	assign sh_fill = (op_code == cbse_pkg::op_rotate_left_carry || op_code == cbse_pkg::op_rotate_right_carry)
		? cbse_pkg::fill_carry
		: (op_code == cbse_pkg::op_arithmetic_right_shift) ? cbse_pkg::fill_keep : cbse_pkg::fill_zero;

	cbse_shift_unit u_shift (.din(rf_q[op_reg]), .cin(status[cbse_pkg::FLAG_C]), .left(sh_left), .fill(sh_fill),
		.sts_in(status), .res(sh_res), .sts_out(sh_sts));
	cbse_bit_write #(.W(8)) u_iobit (.din(io_q[bit_io]), .idx(op_bit), .val(val_io), .dout(iobit_res));
	cbse_bit_write #(.W(8)) u_tbit (.din(rf_q[op_reg]), .idx(op_bit), .val(status[cbse_pkg::FLAG_T]),
		.dout(tbit_res));
	cbse_bit_write #(.W(8)) u_flag (.din(status), .idx(op_bit), .val(val_flag), .dout(flag_res));
	// t goes through the same bit writer so no other flag can move
	cbse_bit_write #(.W(8)) u_tflag (.din(status), .idx(cbse_pkg::FLAG_T), .val(rf_q[op_reg][op_bit]),
		.dout(tflag_res));

	// sequencing of multi-cycle operations
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q <= st_idle;
			cnt_q   <= 2'h0;
			pop_q   <= 1'b0;
			ext_q   <= 1'b0;
			dst_q   <= 5'h00;
		end else begin
			case (state_q)
				st_idle: begin
					if (take && op_code == cbse_pkg::op_stack_push) begin
						state_q <= st_mem;
						cnt_q   <= cbse_pkg::PUSH_LOAD; // [RULE_03] [RULE_13]
						pop_q   <= 1'b0;
						ext_q   <= (sp > SRAM_TOP);
					end else if (take && op_code == cbse_pkg::op_stack_pop) begin
						state_q <= st_mem;
						cnt_q   <= cbse_pkg::POP_LOAD; // [RULE_04] [RULE_13]
						pop_q   <= 1'b1;
						ext_q   <= (sp_up > SRAM_TOP);
						dst_q   <= op_reg;
					end else if (take && op_code == cbse_pkg::op_program_memory_store) begin
						state_q <= st_pmem;
					end
				end
				st_mem: begin
					if (mem_done) begin
						state_q <= st_idle;
					end else if (cnt_q != 2'h0) begin
						cnt_q <= cnt_q - 2'h1;
					end
				end
				st_pmem: begin
					if (pm_ack) begin
						state_q <= st_idle;
					end
				end
				default: begin
					state_q <= st_idle;
				end
			endcase
		end
	end

	// data memory port for the stack
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dm_req_q   <= 1'b0;
			dm_we_q    <= 1'b0;
			dm_addr_q  <= 16'h0000;
			dm_wdata_q <= 8'h00;
		end else if (take && op_code == cbse_pkg::op_stack_push) begin
			dm_req_q   <= 1'b1;
			dm_we_q    <= 1'b1;
			dm_addr_q  <= sp;
			dm_wdata_q <= rf_q[op_reg];
		end else if (take && op_code == cbse_pkg::op_stack_pop) begin
			dm_req_q  <= 1'b1;
			dm_we_q   <= 1'b0;
			dm_addr_q <= sp_up;
		end else if (state_q == st_mem && (!ext_q || dm_ack)) begin
			dm_req_q <= 1'b0;
			dm_we_q  <= 1'b0;
		end
	end

	// program memory store port, held until the memory accepts
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pm_req_q   <= 1'b0;
			pm_addr_q  <= 24'h000000;
			pm_wdata_q <= 16'h0000;
		end else if (take && op_code == cbse_pkg::op_program_memory_store) begin
			pm_req_q   <= 1'b1;
			pm_addr_q  <= {io_q[cbse_pkg::IO_PTR_EXT], zptr}; // [RULE_01]
			pm_wdata_q <= {rf_q[1], rf_q[0]};
		end else if (pm_done) begin
			pm_req_q <= 1'b0;
		end
	end

	// general registers; the core wins over a bus write in the same cycle
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < cbse_pkg::REG_COUNT; i++) begin
				rf_q[i] <= 8'h00;
			end
		end else begin
			if (reg_we && reg_addr < cbse_pkg::BUS_IO_BASE) begin
				rf_q[reg_addr[4:0]] <= reg_wdata;
			end
			if (take) begin
				case (op_code)
					cbse_pkg::op_io_read: begin
						rf_q[op_reg] <= io_q[op_io]; // [RULE_02]
					end
					cbse_pkg::op_logical_left_shift,
					cbse_pkg::op_rotate_left_carry,
					cbse_pkg::op_logical_right_shift,
					cbse_pkg::op_rotate_right_carry,
					cbse_pkg::op_arithmetic_right_shift: begin
						rf_q[op_reg] <= sh_res; // [RULE_05] [RULE_06]
					end
					cbse_pkg::op_transfer_flag_to_bit: begin
						rf_q[op_reg] <= tbit_res; // [RULE_09]
					end
					default: begin
					end
				endcase
			end
			if (mem_done && pop_q) begin
				rf_q[dst_q] <= dm_rdata; // [RULE_04]
			end
			if (pm_done) begin
				rf_q[30] <= zptr[7:0] + cbse_pkg::PM_STEP[7:0]; // [RULE_01]
				rf_q[31] <= 8'(zptr + cbse_pkg::PM_STEP >> 8);
			end
		end
	end

	// i/o space, holding stack pointer, pointer extension and status flags
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < cbse_pkg::IO_COUNT; i++) begin
				io_q[i] <= 8'h00;
			end
			io_q[cbse_pkg::IO_SP_LO] <= SP_INIT[7:0];
			io_q[cbse_pkg::IO_SP_HI] <= SP_INIT[15:8];
		end else begin
			if (reg_we && reg_addr >= cbse_pkg::BUS_IO_BASE && reg_addr <= cbse_pkg::BUS_IO_TOP) begin
				io_q[bus_io] <= reg_wdata;
			end
			if (take) begin
				case (op_code)
					cbse_pkg::op_io_write: begin
						io_q[op_io] <= rf_q[op_reg]; // [RULE_02]
					end
					cbse_pkg::op_io_bit_force_one,
					cbse_pkg::op_io_bit_force_zero: begin
						io_q[bit_io] <= iobit_res; // [RULE_07]
					end
					cbse_pkg::op_logical_left_shift,
					cbse_pkg::op_rotate_left_carry,
					cbse_pkg::op_logical_right_shift,
					cbse_pkg::op_rotate_right_carry,
					cbse_pkg::op_arithmetic_right_shift: begin
						io_q[cbse_pkg::IO_STATUS] <= sh_sts; // [RULE_05] [RULE_06]
					end
					cbse_pkg::op_bit_to_transfer_flag: begin
						io_q[cbse_pkg::IO_STATUS] <= tflag_res; // [RULE_08]
					end
					cbse_pkg::op_indexed_flag_force_one,
					cbse_pkg::op_indexed_flag_force_zero: begin
						io_q[cbse_pkg::IO_STATUS] <= flag_res; // [RULE_10]
					end
					cbse_pkg::op_stack_push: begin
						io_q[cbse_pkg::IO_SP_LO] <= sp[7:0] - 8'h01; // [RULE_03]
						io_q[cbse_pkg::IO_SP_HI] <= 8'((sp - 16'h0001) >> 8);
					end
					cbse_pkg::op_stack_pop: begin
						io_q[cbse_pkg::IO_SP_LO] <= sp_up[7:0]; // [RULE_04]
						io_q[cbse_pkg::IO_SP_HI] <= sp_up[15:8];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// completion and control pulses; control ops touch no flag
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			op_done_q     <= 1'b0;
			sleep_req_q   <= 1'b0;
			break_req_q   <= 1'b0;
			wdt_restart_q <= 1'b0;
		end else begin
			op_done_q     <= (take && !multi) || mem_done || pm_done;
			sleep_req_q   <= take && op_code == cbse_pkg::op_sleep; // [RULE_11]
			break_req_q   <= take && op_code == cbse_pkg::op_break;
			wdt_restart_q <= take && op_code == cbse_pkg::op_watchdog_restart;
		end
	end

	// register bus read, answered one cycle later
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_re) begin
			if (reg_addr < cbse_pkg::BUS_IO_BASE) begin
				reg_rdata_q <= rf_q[reg_addr[4:0]];
			end else if (reg_addr <= cbse_pkg::BUS_IO_TOP) begin
				reg_rdata_q <= io_q[bus_io];
			end else begin
				reg_rdata_q <= 8'h00;
			end
		end
	end

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	logic sts_bus;
	assign sts_bus = reg_we && (bus_io == cbse_pkg::IO_STATUS) && reg_addr >= cbse_pkg::BUS_IO_BASE;

	a_pm_z_step: assert property (pm_done |=> zptr == $past(zptr) + cbse_pkg::PM_STEP) // [RULE_01]
		else $error("z not advanced by two after program store");
	a_io_read_copy: assert property (take && op_code == cbse_pkg::op_io_read && op_reg != dst_q
		|=> rf_q[$past(op_reg)] == $past(io_q[op_io]) && op_ready) // [RULE_02]
		else $error("io read did not copy in one cycle");
	a_push_cycles: assert property (take && op_code == cbse_pkg::op_stack_push && sp <= SRAM_TOP
		|=> !op_ready ##1 op_ready) // [RULE_03]
		else $error("internal push not two cycles");
	a_pop_cycles: assert property (take && op_code == cbse_pkg::op_stack_pop && sp_up <= SRAM_TOP
		|=> !op_ready [*2] ##1 op_ready) // [RULE_04]
		else $error("internal pop not three cycles");
	a_left_shift: assert property (take && op_code == cbse_pkg::op_logical_left_shift && !sts_bus
		|=> rf_q[$past(op_reg)] == {$past(rf_q[op_reg][6:0]), 1'b0}
		&& status[cbse_pkg::FLAG_C] == $past(rf_q[op_reg][7])) // [RULE_05]
		else $error("left shift result or carry wrong");
	a_right_keep_h: assert property (take && !sh_left && !sts_bus && (op_code == cbse_pkg::op_logical_right_shift
		|| op_code == cbse_pkg::op_arithmetic_right_shift || op_code == cbse_pkg::op_rotate_right_carry)
		|=> $stable(status[cbse_pkg::FLAG_H]) && status[cbse_pkg::FLAG_C] == $past(rf_q[op_reg][0])) // [RULE_06]
		else $error("right shift disturbed h or carry wrong");
	a_io_bit_one: assert property (take && op_code == cbse_pkg::op_io_bit_force_one
		&& !(reg_we && reg_addr >= cbse_pkg::BUS_IO_BASE)
		|=> io_q[$past(bit_io)] == ($past(io_q[bit_io]) | (8'h01 << $past(op_bit)))) // [RULE_07]
		else $error("io bit force one wrong");
	a_tflag_load: assert property (take && op_code == cbse_pkg::op_bit_to_transfer_flag && !sts_bus
		|=> status == $past(tflag_res) && status[cbse_pkg::FLAG_T] == $past(rf_q[op_reg][op_bit])) // [RULE_08]
		else $error("transfer flag not loaded");
	a_tflag_to_bit: assert property (take && op_code == cbse_pkg::op_transfer_flag_to_bit
		|=> rf_q[$past(op_reg)][$past(op_bit)] == $past(status[cbse_pkg::FLAG_T])) // [RULE_09]
		else $error("register bit not loaded from t");
	a_flag_zero: assert property (take && op_code == cbse_pkg::op_indexed_flag_force_zero && !sts_bus
		|=> !status[$past(op_bit)] && ((status ^ $past(status)) & ~(8'h01 << $past(op_bit))) == 8'h00) // [RULE_10]
		else $error("flag force zero touched other flags");
	a_ctl_flags: assert property (take && !sts_bus && (op_code == cbse_pkg::op_no_operation
		|| op_code == cbse_pkg::op_sleep || op_code == cbse_pkg::op_break
		|| op_code == cbse_pkg::op_watchdog_restart)
		|=> $stable(status) && op_done_q) // [RULE_11]
		else $error("control op changed flags");

	c_push: cover property (take && op_code == cbse_pkg::op_stack_push ##2 op_done_q);
	c_pop: cover property (take && op_code == cbse_pkg::op_stack_pop ##3 op_done_q);
	c_pm_store: cover property (pm_done);
	c_shift_pair: cover property (take && sh_left ##1 take && !sh_left);

endmodule // cbse_exec_core
`default_nettype wire

// ### cbse_exec_core_tb.sv
// self-checking bench for the bit, stack and i/o execute block
`timescale 1ns/100ps
`default_nettype none
module cbse_exec_core_tb;
	logic               clk_sys;
	logic               reset;
	logic               op_valid;
	cbse_pkg::cbse_op_t op_code;
	logic [4:0]         op_reg;
	logic [5:0]         op_io;
	logic [2:0]         op_bit;
	logic               op_ready;
	logic               op_done_q;
	logic [6:0]         reg_addr;
	logic [7:0]         reg_wdata;
	logic               reg_we;
	logic               reg_re;
	logic [7:0]         reg_rdata_q;
	logic               dm_req_q;
	logic               dm_we_q;
	logic [15:0]        dm_addr_q;
	logic [7:0]         dm_wdata_q;
	logic [7:0]         dm_rdata;
	logic               dm_ack;
	logic               pm_req_q;
	logic [23:0]        pm_addr_q;
	logic [15:0]        pm_wdata_q;
	logic               pm_ack;
	logic               sleep_req_q;
	logic               break_req_q;
	logic               wdt_restart_q;
	logic [7:0]         mem [256];
	logic [2:0]         dm_cnt;
	logic [2:0]         pm_cnt;
	logic [23:0]        pm_cap_a;
	logic [15:0]        pm_cap_d;
	logic [2:0]         pulses;
	int                 err_count = 0;
	int                 cmp_count = 0;
	int                 seed = 32'hb6b2;

	cbse_exec_core i_cbse_exec_core (.clk_sys(clk_sys), .reset(reset), .op_valid(op_valid), .op_code(op_code),
		.op_reg(op_reg), .op_io(op_io), .op_bit(op_bit), .op_ready(op_ready), .op_done_q(op_done_q),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q),
		.dm_req_q(dm_req_q), .dm_we_q(dm_we_q), .dm_addr_q(dm_addr_q), .dm_wdata_q(dm_wdata_q),
		.dm_rdata(dm_rdata), .dm_ack(dm_ack), .pm_req_q(pm_req_q), .pm_addr_q(pm_addr_q),
		.pm_wdata_q(pm_wdata_q), .pm_ack(pm_ack), .sleep_req_q(sleep_req_q), .break_req_q(break_req_q),
		.wdt_restart_q(wdt_restart_q));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// data memory: internal answers the cycle after req, external acks late
	always @(posedge clk_sys) begin
		if (dm_req_q === 1'b1 && dm_we_q === 1'b1)
			mem[dm_addr_q[7:0]] <= dm_wdata_q;
		// released data lines flip so stale values never match by luck
		dm_rdata <= (dm_req_q === 1'b1) ? mem[dm_addr_q[7:0]] : ~dm_rdata;
		if (dm_req_q === 1'b1 && dm_addr_q > 16'h3fff && !dm_ack) begin
			dm_cnt <= dm_cnt + 3'h1;
			dm_ack <= (dm_cnt == 3'h3);
		end else begin
			dm_cnt <= 3'h0;
			dm_ack <= 1'b0;
		end
		if (pm_req_q === 1'b1 && !pm_ack) begin
			pm_cnt <= pm_cnt + 3'h1;
			pm_ack <= (pm_cnt == 3'h2);
			pm_cap_a <= pm_addr_q;
			pm_cap_d <= pm_wdata_q;
		end else begin
			pm_cnt <= 3'h0;
			pm_ack <= 1'b0;
		end
	end

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus_wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_we <= 1'b0;
	endtask

	task automatic bus_rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		#1;
		d = reg_rdata_q;
	endtask

	// ops are offered only while idle, so the offering edge is the taking edge
	task automatic run_op(input cbse_pkg::cbse_op_t c, input logic [4:0] r, input logic [5:0] io,
		input logic [2:0] b, output int n);
		@(posedge clk_sys);
		op_valid <= 1'b1;
		op_code <= c;
		op_reg <= r;
		op_io <= io;
		op_bit <= b;
		@(posedge clk_sys);
		op_valid <= 1'b0;
		#1;
		n = 1;
		pulses = {sleep_req_q, break_req_q, wdt_restart_q};
		while (op_done_q !== 1'b1 && n < 40) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask

	function automatic logic [15:0] shift_exp(input cbse_pkg::cbse_op_t c, input logic [7:0] d, input logic [7:0] s);
		logic [7:0] r;
		logic [7:0] f;
		logic       left;
		f = s;
		left = (c == cbse_pkg::op_logical_left_shift) || (c == cbse_pkg::op_rotate_left_carry);
		case (c)
			cbse_pkg::op_logical_left_shift:  r = {d[6:0], 1'b0};
			cbse_pkg::op_rotate_left_carry:   r = {d[6:0], s[0]};
			cbse_pkg::op_logical_right_shift: r = {1'b0, d[7:1]};
			cbse_pkg::op_rotate_right_carry:  r = {s[0], d[7:1]};
			default:                          r = {d[7], d[7:1]};
		endcase
		f[0] = left ? d[7] : d[0];
		if (left)
			f[5] = d[3];
		f[1] = (r == 8'h00);
		f[2] = r[7];
		f[3] = r[7] ^ f[0];
		return {r, f};
	endfunction

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#100000;
		err_count++;
		complete_run();
	end

	initial begin
		cbse_pkg::cbse_op_t ops [9];
		logic [7:0]         d, s, v, q, q2;
		logic [4:0]         r;
		logic [15:0]        e;
		int                 n;
		ops = '{cbse_pkg::op_logical_left_shift, cbse_pkg::op_rotate_left_carry, cbse_pkg::op_logical_right_shift,
			cbse_pkg::op_rotate_right_carry, cbse_pkg::op_arithmetic_right_shift, cbse_pkg::op_no_operation,
			cbse_pkg::op_break, cbse_pkg::op_sleep, cbse_pkg::op_watchdog_restart};
		{reset, op_valid, reg_we, reg_re, dm_ack, pm_ack} = 6'h20;
		{op_reg, op_io, op_bit, reg_addr, reg_wdata, dm_rdata, dm_cnt, pm_cnt} = '0;
		op_code = cbse_pkg::op_no_operation;
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		bus_rd(7'h5d, q); chk(q, 8'hff);
		bus_rd(7'h5e, q); chk(q, 8'h3f);
		bus_rd(7'h5f, q); chk(q, 8'h00);
		bus_wr(7'h7f, 8'h5a);
		bus_rd(7'h7f, q); chk(q, 8'h00);
		$display("test reset and map done");
		for (int i = 0; i < 25; i++) begin
			d = (i < 5) ? 8'h81 : 8'($random(seed));
			s = (i < 5) ? 8'h00 : 8'($random(seed));
			r = 5'($random(seed));
			bus_wr(7'(r), d);
			bus_wr(7'h5f, s);
			run_op(ops[i % 5], r, 6'h00, 3'h0, n);
			chk(n, 1);
			bus_rd(7'(r), q);
			bus_rd(7'h5f, q2);
			chk({q, q2}, shift_exp(ops[i % 5], d, s));
		end
		$display("test shifts done");
		for (int b = 0; b < 8; b++) begin
			v = 8'($random(seed));
			s = 8'($random(seed));
			r = 5'($random(seed)) | 5'h04;
			bus_wr(7'h5f, s);
			bus_wr(7'h02, v);
			run_op(cbse_pkg::op_io_write, 5'h02, 6'(r), 3'h0, n);
			chk(n, 1);
			bus_rd(7'h20 + 7'(r), q); chk(q, v);
			run_op(cbse_pkg::op_io_read, 5'h03, 6'(r), 3'h0, n);
			bus_rd(7'h03, q); chk(q, v);
			run_op(cbse_pkg::op_io_bit_force_one, 5'h00, 6'(r), 3'(b), n);
			chk(n, 1);
			bus_rd(7'h20 + 7'(r), q); chk(q, v | (8'h01 << b));
			run_op(cbse_pkg::op_io_bit_force_zero, 5'h00, 6'(r), 3'(b), n);
			bus_rd(7'h20 + 7'(r), q); chk(q, v & ~(8'h01 << b));
			bus_rd(7'h5f, q); chk(q, s);
			run_op(cbse_pkg::op_bit_to_transfer_flag, 5'h02, 6'h00, 3'(b), n);
			chk(n, 1);
			bus_rd(7'h5f, q); chk(q, {s[7], v[b], s[5:0]});
			bus_wr(7'h04, ~v);
			run_op(cbse_pkg::op_transfer_flag_to_bit, 5'h04, 6'h00, 3'(b), n);
			chk(n, 1);
			e[7:0] = ~v;
			e[b] = v[b];
			bus_rd(7'h04, q); chk(q, e[7:0]);
			bus_rd(7'h5f, q); chk(q, {s[7], v[b], s[5:0]});
			run_op(cbse_pkg::op_indexed_flag_force_one, 5'h00, 6'h00, 3'(b), n);
			chk(n, 1);
			bus_rd(7'h5f, q); chk(q, {s[7], v[b], s[5:0]} | (8'h01 << b));
			bus_wr(7'h5f, s);
			run_op(cbse_pkg::op_indexed_flag_force_zero, 5'h00, 6'h00, 3'(b), n);
			bus_rd(7'h5f, q); chk(q, s & ~(8'h01 << b));
		end
		$display("test io bit and flag ops done");
		for (int i = 5; i < 9; i++) begin
			bus_wr(7'h5f, 8'ha5);
			run_op(ops[i], 5'h00, 6'h00, 3'h0, n);
			chk(n, 1);
			chk(pulses, (i == 7) ? 3'h4 : (i == 6) ? 3'h2 : (i == 8) ? 3'h1 : 3'h0);
			bus_rd(7'h5f, q); chk(q, 8'ha5);
		end
		$display("test control ops done");
		// second pass moves the stack into the external region, where counts stretch
		for (int k = 0; k < 2; k++) begin
			v = 8'($random(seed));
			e = (k == 0) ? 16'h3fff : 16'h4010;
			bus_wr(7'h5e, e[15:8]);
			bus_wr(7'h5d, e[7:0]);
			bus_wr(7'h05, v);
			bus_wr(7'h5f, 8'h3c);
			run_op(cbse_pkg::op_stack_push, 5'h05, 6'h00, 3'h0, n);
			if (k == 0)
				chk(n, 2);
			else
				chk(n, 6);
			chk(mem[e[7:0]], v);
			bus_rd(7'h5d, q); chk(q, e[7:0] - 8'h01);
			run_op(cbse_pkg::op_stack_pop, 5'h06, 6'h00, 3'h0, n);
			if (k == 0)
				chk(n, 3);
			else
				chk(n, 6);
			bus_rd(7'h06, q); chk(q, v);
			bus_rd(7'h5d, q); chk(q, e[7:0]);
			bus_rd(7'h5f, q); chk(q, 8'h3c);
		end
		$display("test stack done");
		for (int k = 0; k < 2; k++) begin
			e = (k == 0) ? 16'hffff : 16'($random(seed));
			d = 8'($random(seed));
			v = 8'($random(seed));
			s = 8'($random(seed));
			bus_wr(7'h1e, e[7:0]);
			bus_wr(7'h1f, e[15:8]);
			bus_wr(7'h00, d);
			bus_wr(7'h01, v);
			bus_wr(7'h5b, s);
			bus_wr(7'h5f, 8'h96);
			run_op(cbse_pkg::op_program_memory_store, 5'h00, 6'h00, 3'h0, n);
			chk(pm_cap_a, {s, e});
			chk(pm_cap_d, {v, d});
			bus_rd(7'h1e, q);
			bus_rd(7'h1f, q2);
			chk({q2, q}, 16'(e + 16'h0002));
			bus_rd(7'h5b, q); chk(q, s);
			bus_rd(7'h5f, q); chk(q, 8'h96);
		end
		$display("test program store done");
		complete_run();
	end
endmodule // cbse_exec_core_tb
`default_nettype wire
